// file: vsr_pkg.sv
/*
  shared constants of the voltage scan readout block: register offsets,
  field positions, reset values, scan timing and the sequencer states.
  assumes a 250 MHz system clock and a 6-bit register address from the
  single-wire bus engine that sits outside this block.
*/
package vsr_pkg;

  // register offsets on the function's register port
  localparam logic [5:0]  OFF_CAPS       = 6'h10;
  localparam logic [5:0]  OFF_READOUT    = 6'h11;
  localparam logic [5:0]  OFF_CTRL       = 6'h12;

  // sizes
  localparam int          NUM_INPUTS     = 5;
  localparam int          RES_W          = 9;
  localparam int          INPUT_NUMBER_FIELD_W         = 3;
  localparam int          REG_W          = 16;

  // readout register layout
  localparam int          RO_RES_LSB     = 7;
  localparam int          RO_INPUT_NUMBER_FIELD_LSB    = 2;

  // control register layout and reset value
  localparam int          CTRL_ATE_BIT   = 5;
  localparam int          CTRL_EN_LSB    = 6;
  localparam logic [4:0]  CTRL_LOWRATE   = 5'h1F;
  localparam logic [15:0] CTRL_RESET     = 16'h001F;

  // capabilities fields
  localparam logic [2:0]  CAPS_RES_CODE  = 3'h1;
  localparam logic [0:0]  CAPS_ROUT_BIT  = 1'h0;
  localparam logic [4:0]  CAPS_NUM_SENS  = 5'h05;
  localparam int          CAPS_ROUT_POS  = 3;
  localparam int          CAPS_NUM_LSB   = 4;
  localparam logic [15:0] CAPS_VALUE     = 16'h0051;

  // function type descriptor of the voltage-only function
  localparam logic [3:0]  FUNC_TYPE_CODE = 4'h2;

  // scan timing: whole scan refreshed at least every 250 ms, every 1000 ms in low-power mode
  localparam int          CLK_MHZ        = 250;
  localparam int          SCAN_PERIOD_MS = 250;
  localparam int          SCAN_CYCLES    = SCAN_PERIOD_MS * CLK_MHZ * 1000;
  // per-input slot rounds down, a longest time
  localparam int          SLOT_CYCLES    = SCAN_CYCLES / NUM_INPUTS;
  localparam int          LOWPWR_FACTOR  = 4;

  // sequencer states
  typedef enum logic {
    ST_WAIT,
    ST_CONV
  } vsr_state_e;

endpackage : vsr_pkg

// file: vsr_scan_sel.sv
/*
  next-input picker for the voltage scan: from the last scanned input and
  the enable bits it finds the next enabled input in ascending order,
  wrapping after the highest. purely combinational; the caller registers.
*/
module vsr_scan_sel
  import vsr_pkg::*;
#(
  parameter int N = NUM_INPUTS
) (
  input  wire logic [N-1:0]      en,
  input  wire logic [INPUT_NUMBER_FIELD_W-1:0] last,
  output logic      [INPUT_NUMBER_FIELD_W-1:0] next,
  output logic                   any
);

  logic [N-1:0]      rot_en;
  logic [INPUT_NUMBER_FIELD_W-1:0] rot_idx [N];

  // rotate enables so that entry 0 is the input after the last one
  for (genvar i = 0; i < N; i++) begin : g_rot
    always_comb begin
      rot_idx[i] = INPUT_NUMBER_FIELD_W'((int'(last) + 1 + i) % N);
      rot_en[i]  = en[rot_idx[i]];
    end
  end

  // lowest rotated entry wins; disabled inputs are skipped
  always_comb begin
    next = last;
    any  = |en;
    for (int k = N - 1; k >= 0; k--) begin
      if (rot_en[k]) begin
        next = rot_idx[k]; // R02
      end
    end
  end

endmodule : vsr_scan_sel

// file: vsr_rate_timer.sv
/*
  scan pacing timer: emits a one-cycle tick once per input slot, and
  stretches the slot fourfold while the device is in low-power mode.
  free running from reset, so the scan needs no trigger.
*/
module vsr_rate_timer
  import vsr_pkg::*;
#(
  parameter int SLOT = SLOT_CYCLES
) (
  input  wire logic CLK_SYS,
  input  wire logic ARST_N,
  input  wire logic low_power,
  output logic      tick
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } vsr_tmr_s;

  vsr_tmr_s q;
  vsr_tmr_s d;
  logic [31:0] limit;

  // low-power mode runs at a quarter of the active rate
  always_comb begin
    limit  = (low_power ? 32'(SLOT * LOWPWR_FACTOR) : 32'(SLOT)) - 32'h1; // R05
    d      = q;
    d.tick = 1'b0;
    if (q.cnt >= limit) begin
      d.cnt  = 32'h0;
      d.tick = 1'b1; // R03
    end else begin
      d.cnt = q.cnt + 32'h1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule : vsr_rate_timer

// file: vsr_readout.sv
/*
  voltage scan readout: sequencing of the enabled voltage inputs, result
  storage, new-result and overrun flags, attention request and the
  function's three registers (capabilities, readout, control).
  assumes a bus engine on the same clock that issues register reads and
  writes as one-cycle strobes, and an analog converter on the same clock
  that answers each start pulse with one done pulse and a signed code.
*/
// Functional notes
// R01: only enabled inputs join the scan
// R02: ascending round-robin order, disabled inputs skipped
// R03: scan repeats continuously without a trigger
// R04: whole scan refreshes within 250 ms
// R05: low-power mode scans at quarter rate
// R06: stored result raises event, sets sticky flag
// R07: readout read clears new-result flag
// R08: unread result overwritten, overrun flag set
// R09: readout read clears overrun flag
// R10: pace conversions so master can read
// R11: attention only when attention enable set
// R12: common unsigned nine-bit fixed format
// R13: out-of-range codes clamp, never wrap
// R14: setting enables alone starts measurement
// R15: function type code reads 0010
// R16: resolution field 001, data left aligned
// R17: readout width bit reads zero
// R18: sensor count field reads five
// R19: capabilities reads 0051h, reserved zero
// R20: result bits 15-7, input number 4-2
// R21: enables 10-6, attention enable 5, reset clear
// R22: flag set beats read clear
module vsr_readout
  import vsr_pkg::*;
#(
  parameter int SLOT  = SLOT_CYCLES,
  parameter int RAW_W = 12
) (
  input  wire logic                    CLK_SYS,
  input  wire logic                    ARST_N,
  // register port from the bus engine
  input  wire logic [5:0]              REG_ADDR,
  input  wire logic                    REG_RD,
  input  wire logic                    REG_WR,
  input  wire logic [REG_W-1:0]        REG_WDATA,
  output logic      [REG_W-1:0]        REG_RDATA,
  output logic                         REG_RVALID,
  // power mode
  input  wire logic                    LOW_POWER,
  // converter handshake
  output logic                         CONV_START,
  output logic      [INPUT_NUMBER_FIELD_W-1:0]       CONV_SEL,
  input  wire logic                    ADC_DONE,
  input  wire logic signed [RAW_W-1:0] ADC_RAW,
  // device status bits and events
  output logic                         VOLTAGE_NEW_RESULT_FLAG,
  output logic                         VOLTAGE_OVERRUN_FLAG,
  output logic                         FUNC_EVENT,
  output logic                         ATTN_REQ,
  output logic      [3:0]              FUNCTION_TYPE_CODE
);

  typedef struct packed {
    vsr_state_e              st;
    logic [INPUT_NUMBER_FIELD_W-1:0]       cur;
    logic [NUM_INPUTS-1:0]   en;
    logic                    ate;
    logic [RES_W-1:0]        res;
    logic [INPUT_NUMBER_FIELD_W-1:0]       input_number_field;
    logic                    newf;
    logic                    ovr;
    logic [REG_W-1:0]        rdata;
    logic                    rvalid;
    logic                    conv_start;
    logic [INPUT_NUMBER_FIELD_W-1:0]       conv_sel;
    logic                    event_p;
    logic                    attn;
    logic [3:0]              ftype;
  } vsr_state_s;

  vsr_state_s q;
  vsr_state_s d;

  logic              tick;
  logic [INPUT_NUMBER_FIELD_W-1:0] next_ch;
  logic              any_en;
  logic              rd_readout;
  logic              store;
  logic [RES_W-1:0]  clamped;
  logic [REG_W-1:0]  caps_word;
  logic [REG_W-1:0]  ctrl_word;
  logic [REG_W-1:0]  readout_word;

  // slot pacing; the gap between slots is what gives the master time
  vsr_rate_timer #(
    .SLOT      (SLOT)
  ) u_timer (
    .CLK_SYS   (CLK_SYS),
    .ARST_N    (ARST_N),
    .low_power (LOW_POWER),
    .tick      (tick)
  );

  vsr_scan_sel #(
    .N    (NUM_INPUTS)
  ) u_sel (
    .en   (q.en),
    .last (q.cur),
    .next (next_ch),
    .any  (any_en)
  );

  // saturate the converter code to the unsigned nine-bit range
  always_comb begin
    if (ADC_RAW < 0) begin
      clamped = '0; // R13
    end else if (ADC_RAW > $signed({1'b0, {RES_W{1'b1}}})) begin
      clamped = {RES_W{1'b1}}; // R13
    end else begin
      clamped = ADC_RAW[RES_W-1:0]; // R12
    end
  end

  // register read images; capabilities fixed, control and readout from state
  always_comb begin
    caps_word = '0; // R19
    caps_word[2:0] = CAPS_RES_CODE; // R16
    caps_word[CAPS_ROUT_POS] = CAPS_ROUT_BIT[0]; // R17
    caps_word[CAPS_NUM_LSB +: 5] = CAPS_NUM_SENS; // R18
    ctrl_word = '0;
    ctrl_word[4:0] = CTRL_LOWRATE; // low-rate field, read only
    ctrl_word[CTRL_ATE_BIT] = q.ate; // R21
    ctrl_word[CTRL_EN_LSB +: NUM_INPUTS] = q.en; // R21
    readout_word = '0;
    readout_word[RO_RES_LSB +: RES_W] = q.res; // R20
    readout_word[RO_INPUT_NUMBER_FIELD_LSB +: INPUT_NUMBER_FIELD_W] = q.input_number_field; // R20
  end

  // next-state logic of the whole function
  always_comb begin
    d            = q;
    d.conv_start = 1'b0;
    d.event_p    = 1'b0;
    d.attn       = 1'b0;
    d.rvalid     = 1'b0;
    d.ftype      = FUNC_TYPE_CODE; // R15
    rd_readout   = REG_RD && (REG_ADDR == OFF_READOUT);
    store        = 1'b0;

    // scan sequencer: a missed tick during a conversion waits a slot
    unique case (q.st)
      ST_WAIT: begin
        if (tick && any_en) begin // R01 R14
          d.cur        = next_ch; // R02
          d.conv_sel   = next_ch;
          d.conv_start = 1'b1; // R03 R04 R10
          d.st         = ST_CONV;
        end
      end
      ST_CONV: begin
        if (ADC_DONE) begin
          store = 1'b1;
          d.st  = ST_WAIT;
        end
      end
    endcase

    // result storage; an unread result is simply overwritten
    if (store) begin
      d.res     = clamped; // R08
      d.input_number_field    = q.cur;
      d.event_p = 1'b1; // R06
      d.attn    = q.ate && (|q.en); // R11
    end

    // read clears first, a same-cycle store then sets the new-result flag again
    if (rd_readout) begin
      d.newf = 1'b0; // R07
      d.ovr  = 1'b0; // R09
    end
    if (store) begin
      d.newf = 1'b1; // R06 R22
      if (q.newf && !rd_readout) begin
        d.ovr = 1'b1; // R08
      end
    end

    // control writes; low-rate field and reserved bits ignore writes
    if (REG_WR && (REG_ADDR == OFF_CTRL)) begin
      d.ate = REG_WDATA[CTRL_ATE_BIT]; // R21
      d.en  = REG_WDATA[CTRL_EN_LSB +: NUM_INPUTS]; // R01 R21
    end

    // read data, registered; unmapped offsets read zero
    if (REG_RD) begin
      d.rvalid = 1'b1;
      if (REG_ADDR == OFF_CAPS) begin
        d.rdata = caps_word; // R16 R17 R18 R19
      end else if (REG_ADDR == OFF_READOUT) begin
        d.rdata = readout_word; // R20
      end else if (REG_ADDR == OFF_CTRL) begin
        d.rdata = ctrl_word;
      end else begin
        d.rdata = '0;
      end
    end
  end

  // one register bank; control bits clear at device reset
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      q       <= '0; // R21
      q.st    <= ST_WAIT;
      q.ftype <= FUNC_TYPE_CODE;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flip-flops
  assign REG_RDATA               = q.rdata;
  assign REG_RVALID              = q.rvalid;
  assign CONV_START              = q.conv_start;
  assign CONV_SEL                = q.conv_sel;
  assign VOLTAGE_NEW_RESULT_FLAG = q.newf;
  assign VOLTAGE_OVERRUN_FLAG    = q.ovr;
  assign FUNC_EVENT              = q.event_p;
  assign ATTN_REQ                = q.attn;
  assign FUNCTION_TYPE_CODE      = q.ftype;

endmodule : vsr_readout

// file: vsr_readout_asserts.sv
/*
  concurrent checks on the ports of the voltage scan readout block.
  assumes it is bound to vsr_readout and handed the same SLOT count.
*/
module vsr_readout_chk
  import vsr_pkg::*;
#(
  parameter int SLOT = 8
) (
  input wire logic             CLK_SYS,
  input wire logic             ARST_N,
  input wire logic [5:0]       REG_ADDR,
  input wire logic             REG_RD,
  input wire logic [REG_W-1:0] REG_RDATA,
  input wire logic             REG_RVALID,
  input wire logic             CONV_START,
  input wire logic             ADC_DONE,
  input wire logic             VOLTAGE_NEW_RESULT_FLAG,
  input wire logic             VOLTAGE_OVERRUN_FLAG,
  input wire logic             FUNC_EVENT,
  input wire logic             ATTN_REQ,
  input wire logic [3:0]       FUNCTION_TYPE_CODE
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  logic       rd_ro;
  logic       seen_q;
  logic [31:0] gap_q; // wide enough for a full-size slot count
  assign rd_ro = REG_RD && REG_ADDR == OFF_READOUT;
  // cycles since last start; saturates so a long idle never wraps
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      gap_q  <= 32'h0000_0000;
      seen_q <= 1'b0;
    end else if (CONV_START) begin
      gap_q  <= 32'h0000_0000;
      seen_q <= 1'b1;
    end else if (gap_q != 32'hFFFF_FFFF) begin
      gap_q <= gap_q + 32'h0000_0001;
    end
  end
  a_caps_read: assert property (REG_RD && REG_ADDR == OFF_CAPS
    |=> REG_RVALID && REG_RDATA == CAPS_VALUE) else $error("caps bad");
  a_type_code: assert property (FUNCTION_TYPE_CODE == 4'h2)
    else $error("type code bad");
  a_ro_zero: assert property (rd_ro
    |=> REG_RDATA[6:5] == 2'h0 && REG_RDATA[1:0] == 2'h0)
    else $error("readout pad bits set");
  a_read_clear: assert property (rd_ro && !ADC_DONE
    |=> !VOLTAGE_NEW_RESULT_FLAG && !VOLTAGE_OVERRUN_FLAG)
    else $error("flags not cleared by read");
  a_set_wins: assert property (rd_ro && ADC_DONE
    |=> VOLTAGE_NEW_RESULT_FLAG) else $error("read clear beat store");
  a_overrun_set: assert property (ADC_DONE && !rd_ro
    && VOLTAGE_NEW_RESULT_FLAG |=> VOLTAGE_OVERRUN_FLAG)
    else $error("overrun missed");
  a_flag_sticky: assert property (VOLTAGE_NEW_RESULT_FLAG && !rd_ro
    |=> VOLTAGE_NEW_RESULT_FLAG) else $error("new flag dropped");
  a_event_cause: assert property (FUNC_EVENT
    |-> $past(ADC_DONE) && VOLTAGE_NEW_RESULT_FLAG)
    else $error("event without store");
  a_attn_event: assert property (ATTN_REQ |-> FUNC_EVENT)
    else $error("attention without event");
  a_start_gap: assert property (CONV_START && seen_q
    |-> gap_q >= SLOT - 1) else $error("starts too close");
endmodule : vsr_readout_chk

bind vsr_readout vsr_readout_chk #(.SLOT(SLOT)) chk_u (
  .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .CONV_START(CONV_START), .ADC_DONE(ADC_DONE),
  .VOLTAGE_NEW_RESULT_FLAG(VOLTAGE_NEW_RESULT_FLAG),
  .VOLTAGE_OVERRUN_FLAG(VOLTAGE_OVERRUN_FLAG), .FUNC_EVENT(FUNC_EVENT),
  .ATTN_REQ(ATTN_REQ), .FUNCTION_TYPE_CODE(FUNCTION_TYPE_CODE));

// file: vsr_conv_model.sv
/*
  behavioural converter beside the readout block: one done pulse LAT+1
  cycles after each start, with a fixed code per input.
  assumes the block's clock and reset.
*/
module vsr_conv_model
  import vsr_pkg::*;
#(
  parameter int LAT = 2
) (
  input  wire logic              CLK_SYS,
  input  wire logic              ARST_N,
  input  wire logic              CONV_START,
  input  wire logic [INPUT_NUMBER_FIELD_W-1:0] CONV_SEL,
  output logic                   ADC_DONE,
  output logic signed [11:0]     ADC_RAW
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  // below range, above range, then in-range codes
  function automatic logic signed [11:0] code(input logic [2:0] s);
    case (s)
      3'h0:    code = -12'sd3;
      3'h1:    code = 12'sd700;
      default: code = 12'(int'(s) * 100);
    endcase
  endfunction : code
  // code line toggles outside the done cycle so stale data shows
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt      <= 0;
      ADC_DONE <= 1'b0;
      ADC_RAW  <= 12'h0A5;
    end else begin
      cnt      <= CONV_START ? LAT : (cnt > 0 ? cnt - 1 : 0);
      ADC_DONE <= !CONV_START && cnt == 1;
      ADC_RAW  <= (!CONV_START && cnt == 1) ? code(CONV_SEL) : ~ADC_RAW;
    end
  end
endmodule : vsr_conv_model

// file: vsr_readout_tb.sv
/*
  self-checking bench of the voltage scan readout block.
  assumes the converter model and a short SLOT count.
*/
module vsr_readout_tb
  import vsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SL = 8;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic [5:0]         addr = 6'h00;
  logic               rd = 1'b0;
  logic               wr = 1'b0;
  logic               lp = 1'b0;
  logic [15:0]        wdata = 16'h0000;
  logic [15:0]        rdata;
  logic [15:0]        q;
  logic               rvalid, start, done, nf, of, ev, attn;
  logic [2:0]         sel;
  logic signed [11:0] raw;
  logic [3:0]         ftc;
  int                 err_total = 0;
  int                 check_count = 0;

  vsr_readout #(.SLOT(SL)) dut_u (.CLK_SYS(clk), .ARST_N(rst_n),
    .REG_ADDR(addr), .REG_RD(rd), .REG_WR(wr), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .REG_RVALID(rvalid), .LOW_POWER(lp),
    .CONV_START(start), .CONV_SEL(sel), .ADC_DONE(done), .ADC_RAW(raw),
    .VOLTAGE_NEW_RESULT_FLAG(nf), .VOLTAGE_OVERRUN_FLAG(of),
    .FUNC_EVENT(ev), .ATTN_REQ(attn), .FUNCTION_TYPE_CODE(ftc));
  vsr_conv_model conv_u (.CLK_SYS(clk), .ARST_N(rst_n),
    .CONV_START(start), .CONV_SEL(sel), .ADC_DONE(done), .ADC_RAW(raw));

  // free clock at 4 ns
  always #2 clk = ~clk;

  // all drives land 1 ns after the edge
  task automatic tk();
    @(posedge clk);
    #1;
  endtask : tk
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      $display("unexpected at %0t got %h exp %h", $time, g, e);
      err_total++;
    end
  endtask : chk
  task automatic rdr(input logic [5:0] a);
    addr = a;
    rd = 1'b1;
    tk();
    rd = 1'b0;
    q = rdata;
    chk(16'(rvalid), 16'h0001);
    // idle edge so a following read never re-raises rd in this step
    tk();
  endtask : rdr
  task automatic wrr(input logic [5:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tk();
    wr = 1'b0;
  endtask : wrr
  // bounded wait: 0 start, 1 event, 2 converter done
  task automatic wt(input int w);
    int n;
    n = 0;
    while ((w == 0 ? start : w == 1 ? ev : done) !== 1'b1 && n < 300) begin
      tk();
      n++;
    end
    chk(16'(n < 300), 16'h0001);
  endtask : wt
  // clamped result placed with its input number
  function automatic logic [15:0] ro(input logic [2:0] s);
    logic [8:0] r;
    r = s == 3'h0 ? 9'h000 : s == 3'h1 ? 9'h1FF : 9'(int'(s) * 100);
    ro = {r, 2'h0, s, 2'h0};
  endfunction : ro
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (5) tk();
    rst_n = 1'b1;
  endtask : do_reset
  task automatic t_regs();
    rdr(OFF_CAPS);
    chk(q, 16'h0051);
    chk(16'(ftc), 16'h0002);
    rdr(OFF_CTRL);
    chk(q, 16'h001F);
    wrr(OFF_CAPS, 16'hFFFF);
    rdr(6'h3F);
    chk(q, 16'h0000);
    rdr(OFF_CAPS);
    chk(q, 16'h0051);
    repeat (3 * SL) tk();
    chk(16'({nf, ev}), 16'h0000);
    rdr(OFF_READOUT);
    chk(q, 16'h0000);
  endtask : t_regs
  task automatic conv(input logic [2:0] s);
    wt(0);
    chk(16'(sel), 16'(s));
    wt(1);
    chk(16'({attn, nf}), 16'h0003);
    rdr(OFF_READOUT);
    chk(q, ro(s));
    chk(16'({nf, of}), 16'h0000);
  endtask : conv
  task automatic t_scan();
    wrr(OFF_CTRL, 16'h04E0);
    rdr(OFF_CTRL);
    chk(q, 16'h04FF);
    conv(3'h1);
    conv(3'h4);
    conv(3'h0);
    conv(3'h1);
  endtask : t_scan
  // second reset mid-run, then two unread results
  task automatic t_ovr();
    do_reset();
    wrr(OFF_CTRL, 16'h0300);
    wt(1);
    chk(16'(attn), 16'h0000);
    tk();
    wt(1);
    chk(16'({nf, of}), 16'h0003);
    rdr(OFF_READOUT);
    chk(q, ro(3'h3));
    chk(16'({nf, of}), 16'h0000);
  endtask : t_ovr
  // read lands on the edge that stores the next result
  task automatic t_both();
    wt(2);
    rdr(OFF_READOUT);
    chk(q, ro(3'h3));
    chk(16'({nf, of}), 16'h0002);
    rdr(OFF_READOUT);
    chk(q, ro(3'h2));
  endtask : t_both
  task automatic gap(input int e);
    int n;
    wt(0);
    tk();
    wt(0);
    n = 0;
    do begin
      tk();
      n++;
    end while (!start && n < 200);
    chk(16'(n), 16'(e));
  endtask : gap
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_regs();
    t_scan();
    t_ovr();
    t_both();
    lp = 1'b1;
    gap(4 * SL);
    lp = 1'b0;
    gap(SL);
    report_and_stop();
  end
  // watchdog, well past the expected few hundred cycles
  initial begin
    repeat (8000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule : vsr_readout_tb
